// >>> dv/scf_peer.sv
`timescale 1ns/1ps
module scf_peer (
    input wire logic frame,
    input wire logic sel_low,
    output logic link_clk_pin,
    output logic word_select_pin,
    output logic select_pin_in
);
    assign select_pin_in = !sel_low;
    initial begin
        link_clk_pin = 1'h0;
        word_select_pin = 1'h0;
        #3;
        // clock parks low between frames; side moves only on falling edges
        forever begin
            #62.5;
            if (frame && link_clk_pin)
                word_select_pin = !word_select_pin;
            if (frame || link_clk_pin)
                link_clk_pin = !link_clk_pin;
        end
    end
endmodule : scf_peer

// >>> dv/scf_properties.sv
`timescale 1ns/1ps
module scf_properties (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire scf_pkg::scf_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire scf_pkg::scf_evt_t evt,
    input wire scf_pkg::scf_cfg_t cfg,
    input wire logic irq,
    input wire logic dma_tx_req,
    input wire logic dma_rx_req,
    input wire logic sync_frame_mode
);
    logic [7:0] c_q;
    // shadow of the enables; only the low lane can change them
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n)
            c_q <= 8'h00;
        else if (bus_req.write && bus_req.addr == 8'h04 && bus_req.half_en[0])
            c_q <= bus_req.wdata[7:0];
    end
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    sequence rx_set(b);
        evt.rx_done && c_q[b] ##1 c_q[b];
    endsequence
    sequence tx_set;
        evt.tx_loaded && c_q[1] ##1 c_q[1];
    endsequence
    a_rx_dma_req: assert property (rx_set(0) |=> dma_rx_req) else $error("rx dma");
    a_rx_irq_req: assert property (rx_set(6) |=> irq) else $error("rx irq");
    a_tx_dma_req: assert property (tx_set |=> dma_tx_req) else $error("tx dma");
    a_err_irq_req: assert property (evt.crc_bad && !cfg.audio_mode && c_q[5] ##1 c_q[5]
        |=> irq) else $error("err irq");
    a_irq_quiet: assert property (c_q[7:5] == 3'h0 |=> !irq) else $error("irq");
    a_tx_irq_req: assert property (evt.tx_loaded && c_q[7] ##1 c_q[7] |=> irq)
        else $error("tx irq");
    a_mode_copy: assert property (sync_frame_mode == c_q[4]) else $error("mode");
    a_rd_quiet: assert property (!$past(bus_req.read) |-> bus_rdata == 32'h0)
        else $error("rdata");
    a_ctl_read: assert property (bus_req.read && bus_req.addr == 8'h04
        |=> bus_rdata == {24'h0, $past(c_q)}) else $error("ctl read");
endmodule : scf_properties

bind scf_ctrl_status scf_properties i_props (.clk_sys, .reset_n, .bus_req, .bus_rdata, .evt,
    .cfg, .irq, .dma_tx_req, .dma_rx_req, .sync_frame_mode);

// >>> dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    scf_pkg::scf_bus_req_t bus_req = '0;
    scf_pkg::scf_evt_t evt = '0;
    scf_pkg::scf_cfg_t cfg = '0;
    logic frame = 1'h0;
    logic sel_low = 1'h0;
    // word select as the peer shows it at each link clock rise, when the side is taken
    logic ws_at_rise = 1'h0;
    logic [31:0] bus_rdata;
    logic select_pin_in, link_clk_pin, word_select_pin, select_pin_out, select_pin_oe;
    logic irq, dma_tx_req, dma_rx_req, sync_frame_mode, select_pulse_mode;
    int error_cnt = 0;
    int n_compared = 0;
    always #4 clk_sys = !clk_sys;
    scf_ctrl_status i_dut (.clk_sys, .reset_n, .bus_req, .bus_rdata, .evt, .cfg, .select_pin_in,
        .link_clk_pin, .word_select_pin, .select_pin_out, .select_pin_oe, .irq, .dma_tx_req,
        .dma_rx_req, .sync_frame_mode, .select_pulse_mode);
    scf_peer i_peer (.frame, .sel_low, .link_clk_pin, .word_select_pin, .select_pin_in);
    always @(posedge link_clk_pin) ws_at_rise <= word_select_pin;
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            $display("unexpected at %0t got %h exp %h", $time, g, e);
            error_cnt++;
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cy
    // strobes drop one edge before the next access, never in the same step
    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] h);
        bus_req <= '{a, d, h, 1'h1, 1'h0};
        cy(1);
        bus_req.write <= 1'h0;
        cy(1);
    endtask : w
    task automatic r(input logic [7:0] a, input logic [31:0] e);
        bus_req <= '{a, 32'h0, 2'h3, 1'h0, 1'h1};
        cy(1);
        bus_req.read <= 1'h0;
        #1;
        chk(bus_rdata, e);
        cy(1);
    endtask : r
    task automatic ev(input scf_pkg::scf_evt_t e);
        evt <= e;
        cy(1);
        evt <= '0;
        cy(1);
    endtask : ev
    task automatic final_report;
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report
    initial begin
        cy(10);
        reset_n <= 1'h1;
        r(8'h04, 32'h0);
        r(8'h08, 32'h2);
        r(8'h0c, 32'h0);
        w(8'h04, 32'hffffffff, 2'h3);
        w(8'h04, 32'h0, 2'h2);
        r(8'h04, 32'hff);
        chk({sync_frame_mode, select_pulse_mode, irq, dma_tx_req, dma_rx_req}, 5'h1e);
        w(8'h04, 32'h43, 2'h1);
        ev(9'h004);
        r(8'h08, 32'h0);
        ev(9'h100);
        ev(9'h080);
        cy(1);
        chk({irq, dma_rx_req, dma_tx_req}, 3'h7);
        ev(9'h080);
        r(8'h08, 32'h43);
        ev(9'h002);
        r(8'h08, 32'h42);
        r(8'h08, 32'h2);
        w(8'h04, 32'h30, 2'h1);
        ev(9'h040);
        ev(9'h020);
        r(8'h08, 32'h112);
        w(8'h08, 32'h0, 2'h1);
        r(8'h08, 32'h2);
        cfg <= 7'h03;
        ev(9'h010);
        r(8'h08, 32'ha);
        r(8'h08, 32'h2);
        cfg <= 7'h02;
        frame <= 1'h1;
        evt <= 9'h008;
        cy(40);
        frame <= 1'h0;
        cy(40);
        r(8'h08, {29'h0, ws_at_rise, 2'h2} | 32'h80);
        evt <= 9'h000;
        cfg <= 7'h50;
        cy(2);
        r(8'h08, 32'h22);
        cfg <= 7'h58;
        r(8'h08, 32'h22);
        ev(9'h001);
        r(8'h08, 32'h2);
        w(8'h04, 32'h04, 2'h1);
        cfg <= 7'h64;
        cy(3);
        chk({select_pin_oe, select_pin_out}, 2'h2);
        final_report();
    end
endmodule : tb_top

// >>> rtl/scf_ctrl_status.sv
`timescale 1ns/1ps
`include "scf_regs.svh"
module scf_ctrl_status (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire scf_pkg::scf_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire scf_pkg::scf_evt_t evt,
    input wire scf_pkg::scf_cfg_t cfg,
    input wire logic select_pin_in,
    input wire logic link_clk_pin,
    input wire logic word_select_pin,
    output logic select_pin_out,
    output logic select_pin_oe,
    output logic irq,
    output logic dma_tx_req,
    output logic dma_rx_req,
    output logic sync_frame_mode,
    output logic select_pulse_mode
);
    scf_pkg::scf_state_t st_q;
    scf_pkg::scf_state_t st_d;

    function automatic logic scf_hit(input logic [7:0] a, input logic [7:0] off);
        scf_hit = (a == off);
    endfunction : scf_hit

    logic wr_ctl;
    logic wr_stat;
    logic rd_stat;
    logic lo_lane;
    logic lck_rise;
    logic sel_level;
    logic err_any;

    always_comb begin
        st_d = st_q;
        lo_lane = bus_req.half_en[0];
        wr_ctl = bus_req.write && lo_lane && scf_hit(bus_req.addr, `SCF_OFF_CTL);
        wr_stat = bus_req.write && lo_lane && scf_hit(bus_req.addr, `SCF_OFF_STAT);
        rd_stat = bus_req.read && scf_hit(bus_req.addr, `SCF_OFF_STAT);

        // pin inputs pass two flops; only the second stage is read
        st_d.sel_sync = {st_q.sel_sync[0], select_pin_in};
        st_d.lck_sync = {st_q.lck_sync[0], link_clk_pin};
        st_d.ws_sync = {st_q.ws_sync[0], word_select_pin};
        st_d.lck_prev = st_q.lck_sync[1];
        lck_rise = st_q.lck_sync[1] && !st_q.lck_prev;

        // upper half is reserved, so only the low lane can change control
        if (wr_ctl) begin
            st_d.ctl = bus_req.wdata[`SCF_CTL_W-1:0];
        end

        // clears first, hardware sets below so a set in the same cycle wins
        if (wr_stat && !bus_req.wdata[`SCF_S_FORMAT_ERROR_FLAG]) begin
            st_d.stat.format_error_flag = 1'b0;
        end
        if (wr_stat && !bus_req.wdata[`SCF_S_CRC]) begin
            st_d.stat.crc_mismatch_flag = 1'b0;
        end
        if (rd_stat) begin
            st_d.stat.tx_underrun_flag = 1'b0;
        end
        if (evt.data_rd) begin
            st_d.ovr_arm = 1'b1;
        end
        if (rd_stat && st_q.ovr_arm) begin
            st_d.stat.rx_overrun_flag = 1'b0;
            st_d.ovr_arm = 1'b0;
        end
        if (rd_stat || (bus_req.write && scf_hit(bus_req.addr, `SCF_OFF_STAT))) begin
            st_d.conf_arm = 1'b1;
        end
        if (evt.ctl0_wr && st_q.conf_arm) begin
            st_d.stat.config_fault_flag = 1'b0;
            st_d.conf_arm = 1'b0;
        end
        if (evt.data_wr) begin
            st_d.stat.tx_buffer_empty = 1'b0;
        end
        if (evt.data_rd) begin
            st_d.stat.rx_buffer_filled = 1'b0;
        end

        // hardware sets
        if (evt.tx_loaded) begin
            st_d.stat.tx_buffer_empty = 1'b1;
        end
        if (evt.rx_done) begin
            st_d.stat.rx_buffer_filled = 1'b1;
            if (st_q.stat.rx_buffer_filled && !evt.data_rd) begin
                st_d.stat.rx_overrun_flag = 1'b1;
                st_d.ovr_arm = 1'b0;
            end
        end
        if (evt.format_bad && (cfg.audio_mode || st_q.ctl.sync_frame_format_enable)) begin
            st_d.stat.format_error_flag = 1'b1;
        end
        if (evt.crc_bad && !cfg.audio_mode) begin
            st_d.stat.crc_mismatch_flag = 1'b1;
        end
        if (evt.underrun && cfg.audio_mode) begin
            st_d.stat.tx_underrun_flag = 1'b1;
        end
        // select pin level as seen by the fault check, hardware or software
        sel_level = cfg.soft_sel_en ? cfg.soft_sel_level : st_q.sel_sync[1];
        if (cfg.master && !cfg.audio_mode && !sel_level) begin
            st_d.stat.config_fault_flag = 1'b1;
        end
        st_d.stat.transfer_active_flag = evt.frame_busy;
        // side is taken on a link clock edge so it only moves between words
        if (!cfg.audio_mode || cfg.audio_pcm) begin
            st_d.stat.audio_channel_side = 1'b0;
        end else if (lck_rise) begin
            st_d.stat.audio_channel_side = st_q.ws_sync[1];
        end

        err_any = st_q.stat.crc_mismatch_flag || st_q.stat.config_fault_flag
            || st_q.stat.rx_overrun_flag || st_q.stat.tx_underrun_flag;
        st_d.irq = (st_q.ctl.tx_empty_irq_enable && st_q.stat.tx_buffer_empty)
            || (st_q.ctl.rx_full_irq_enable && st_q.stat.rx_buffer_filled)
            || (st_q.ctl.error_irq_enable && err_any);
        st_d.dma_tx = st_q.ctl.tx_dma_request_enable && st_q.stat.tx_buffer_empty;
        st_d.dma_rx = st_q.ctl.rx_dma_request_enable && st_q.stat.rx_buffer_filled;
        // with the pin as input the drive bit is ignored and the peer holds it high
        st_d.sel_oe = st_q.ctl.select_output_drive && cfg.sel_is_output
            && cfg.master && cfg.enable;

        st_d.rdata = `SCF_RD_ZERO;
        if (bus_req.read && scf_hit(bus_req.addr, `SCF_OFF_CTL)) begin
            st_d.rdata[`SCF_CTL_W-1:0] = st_q.ctl;
        end else if (rd_stat) begin
            st_d.rdata[`SCF_STAT_W-1:0] = st_q.stat;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= '0;
            st_q.stat.tx_buffer_empty <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign bus_rdata = st_q.rdata;
    assign irq = st_q.irq;
    assign dma_tx_req = st_q.dma_tx;
    assign dma_rx_req = st_q.dma_rx;
    assign select_pin_oe = st_q.sel_oe;
    assign select_pin_out = 1'b0;
    assign sync_frame_mode = st_q.ctl.sync_frame_format_enable;
    assign select_pulse_mode = st_q.ctl.select_pulse_mode_enable;
endmodule : scf_ctrl_status

// >>> rtl/scf_pkg.sv
package scf_pkg;
    // register port request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [1:0] half_en;
        logic write;
        logic read;
    } scf_bus_req_t;

    // events and levels from the shift engine, same clock
    typedef struct packed {
        logic tx_loaded;
        logic rx_done;
        logic crc_bad;
        logic format_bad;
        logic underrun;
        logic frame_busy;
        logic data_wr;
        logic data_rd;
        logic ctl0_wr;
    } scf_evt_t;

    // settings held in the first control register
    typedef struct packed {
        logic master;
        logic enable;
        logic soft_sel_en;
        logic soft_sel_level;
        logic sel_is_output;
        logic audio_mode;
        logic audio_pcm;
    } scf_cfg_t;

    typedef struct packed {
        logic tx_empty_irq_enable;
        logic rx_full_irq_enable;
        logic error_irq_enable;
        logic sync_frame_format_enable;
        logic select_pulse_mode_enable;
        logic select_output_drive;
        logic tx_dma_request_enable;
        logic rx_dma_request_enable;
    } scf_ctl_t;

    typedef struct packed {
        logic format_error_flag;
        logic transfer_active_flag;
        logic rx_overrun_flag;
        logic config_fault_flag;
        logic crc_mismatch_flag;
        logic tx_underrun_flag;
        logic audio_channel_side;
        logic tx_buffer_empty;
        logic rx_buffer_filled;
    } scf_stat_t;

    typedef struct packed {
        scf_ctl_t ctl;
        scf_stat_t stat;
        logic ovr_arm;
        logic conf_arm;
        logic [1:0] sel_sync;
        logic [1:0] lck_sync;
        logic lck_prev;
        logic [1:0] ws_sync;
        logic irq;
        logic dma_tx;
        logic dma_rx;
        logic sel_oe;
        logic [31:0] rdata;
    } scf_state_t;
endpackage : scf_pkg

// >>> rtl/scf_regs.svh
`ifndef SCF_REGS_SVH
`define SCF_REGS_SVH
// Operation
// - tx-empty flag with its enable raises interrupt
// - rx-filled flag with its enable raises interrupt
// - any error flag except format error, with error enable, interrupts
// - control bit 4 selects sync frame format
// - control bit 3 enables select pulse mode
// - drive bit pulls select low when master, enabled and select set as output
// - tx dma request while tx buffer empty
// - rx dma request while rx buffer filled
// - control resets zero, 16/32-bit access
// - status resets to 0x2, tx empty only
// - format error set by hardware, write-zero clears
// - transfer active flag follows frame activity
// - overrun cleared by data read then status read
// - master select low sets config fault, not audio
// - status access then control0 write clears fault
// - crc mismatch set, write-zero clears, not audio
// - underrun audio only, status read clears
// - channel side tracks audio word select, held zero in pcm
// - status bits show tx empty, rx filled

`define SCF_OFF_CTL 8'h04
`define SCF_OFF_STAT 8'h08
`define SCF_CTL_RST 8'h00
`define SCF_CTL_W 8
`define SCF_C_TX_EMPTY_IRQ_ENABLE 7
`define SCF_C_RX_FULL_IRQ_ENABLE 6
`define SCF_C_ERROR_IRQ_ENABLE 5
`define SCF_C_SYNC 4
`define SCF_C_PULSE 3
`define SCF_C_DRIVE 2
`define SCF_C_TXDMA 1
`define SCF_C_RXDMA 0
`define SCF_S_FORMAT_ERROR_FLAG 8
`define SCF_S_RXOV 6
`define SCF_S_CRC 4
`define SCF_STAT_W 9
`define SCF_RD_ZERO 32'h0000_0000
`endif
